// ---- common/mwd_pkg.sv ----
package mwd_pkg;

  // Datapath widths; word bit 00 is the most significant bit
  localparam int WORD_W = 36;
  localparam int CNT_W = 10;
  localparam int MAGIC_W = 9;
  localparam int VA_W = 23;
  localparam int FMA_W = 7;

  // Word bit positions (index = 35 - documented bit number)
  localparam int AR_SIGN = 35;
  localparam int AR_DIR = 17;
  localparam int ARX_IDX_HI = 21;
  localparam int ARX_IDX_LO = 18;
  localparam int PC_LH_HI = 22;
  localparam int PC_LH_LO = 18;

  // Register offsets on the AXI4-Lite port
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_VADDR = 8'h08;
  localparam logic [7:0] OFS_WEXT = 8'h0C;
  localparam logic [7:0] OFS_BUF = 8'h10;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Work-extension input selects
  localparam logic [2:0] WX_UNUSED = 3'h0;
  localparam logic [2:0] WX_CACHE = 3'h1;
  localparam logic [2:0] WX_SUM = 3'h2;
  localparam logic [2:0] WX_MQ = 3'h3;
  localparam logic [2:0] WX_SHIFT = 3'h4;
  localparam logic [2:0] WX_SUM2 = 3'h5;
  localparam logic [2:0] WX_XSUM = 3'h6;
  localparam logic [2:0] WX_XSUM4 = 3'h7;
  localparam logic [MAGIC_W-1:0] MAGIC_WX_CLR = 9'h003;

  // Count-adder functions
  localparam logic [2:0] CA_A = 3'h0;
  localparam logic [2:0] CA_AMB1 = 3'h1;
  localparam logic [2:0] CA_APB = 3'h2;
  localparam logic [2:0] CA_AM1 = 3'h3;
  localparam logic [2:0] CA_AP1 = 3'h4;
  localparam logic [2:0] CA_AMB = 3'h5;
  localparam logic [2:0] CA_OR = 3'h6;
  localparam logic [2:0] CA_AND = 3'h7;

  // Fast-memory address codes
  localparam logic [2:0] FM_AC0 = 3'h0;
  localparam logic [2:0] FM_AC1 = 3'h1;
  localparam logic [2:0] FM_XR = 3'h2;
  localparam logic [2:0] FM_VA = 3'h3;
  localparam logic [2:0] FM_AC2 = 3'h4;
  localparam logic [2:0] FM_AC3 = 3'h5;
  localparam logic [2:0] FM_CB = 3'h6;
  localparam logic [2:0] FM_MB = 3'h7;

  // Shifter and virtual address codes
  localparam logic [1:0] SH_PAIR = 2'h0;
  localparam logic [1:0] SH_MAIN = 2'h1;
  localparam logic [1:0] SH_EXT = 2'h2;
  localparam logic [1:0] SH_SWAP = 2'h3;
  localparam logic [CNT_W-1:0] SHIFT_MAX = 10'h023;
  localparam logic [1:0] VA_HOLD = 2'h0;
  localparam logic [1:0] VA_PC = 2'h1;
  localparam logic [1:0] VA_PC1 = 2'h2;
  localparam logic [1:0] VA_SUM = 2'h3;

  // Microword fields from the control store
  typedef struct packed {
    logic [2:0] wx_sel;
    logic buf_sel;
    logic bufx_sel;
    logic [2:0] fm_sel;
    logic [2:0] ca_fn;
    logic [2:0] ca_a_sel;
    logic [2:0] ca_b_sel;
    logic sc_src;
    logic [1:0] sh_sel;
    logic [1:0] va_sel;
    logic [MAGIC_W-1:0] magic;
    logic count_mux_alternate;
    logic left_half_indirect_ctl;
    logic sc_load;
    logic exp_load;
  } mwd_mword_type;

  // Datapath values and strobes feeding the selects
  typedef struct packed {
    logic [WORD_W-1:0] main_work_reg;
    logic [WORD_W-1:0] cache_data;
    logic [WORD_W-1:0] sum;
    logic [WORD_W-1:0] extension_sum;
    logic [WORD_W-1:0] mult_quot_reg;
    logic [VA_W-1:0] pc;
    logic [4:0] prev_sect;
    logic [2:0] cur_ac_block;
    logic [3:0] instr_acc_field;
    logic memory_response_strobe;
    logic fastmem_transfer;
    logic main_work_busy;
    logic main_sel_none;
  } mwd_dpath_type;

endpackage

// ---- core/mwd_count_adder.sv ----
`timescale 1ns/1ps
module mwd_count_adder #(
  parameter int CW = mwd_pkg::CNT_W
) (
  // Microword controls
  input wire logic [2:0] fn,
  input wire logic [2:0] a_sel,
  input wire logic [2:0] b_sel,
  input wire logic [mwd_pkg::MAGIC_W-1:0] magic,
  // Operand sources
  input wire logic [CW-1:0] exponent_reg,
  input wire logic [CW-1:0] shift_count_reg,
  input wire logic [mwd_pkg::WORD_W-1:0] main_work_reg,
  // Result
  output logic [CW-1:0] sum
);

  // Zero-extend a narrow field to counter width
  function automatic logic [CW-1:0] ext9(input logic [8:0] v);
    ext9 = {{(CW-9){1'b0}}, v};
  endfunction

  // Operand mixers; codes 4-7 force zeros
  logic [CW-1:0] a_mux;
  logic [CW-1:0] b_mux;
  assign a_mux = (a_sel == 3'h0) ? exponent_reg :
                 (a_sel == 3'h1) ? ext9({3'h0, main_work_reg[35:30]}) :
                 (a_sel == 3'h2) ? ext9(main_work_reg[35:27]) :
                 (a_sel == 3'h3) ? ext9(magic) : '0;
  assign b_mux = (b_sel == 3'h0) ? shift_count_reg :
                 (b_sel == 3'h1) ? ext9({3'h0, main_work_reg[29:24]}) :
                 (b_sel == 3'h2) ? ext9(main_work_reg[35:27]) :
                 (b_sel == 3'h3) ? ext9(magic) : '0;

  // Eight wired functions
  always_comb begin
    case (fn)
      mwd_pkg::CA_A: sum = a_mux;
      mwd_pkg::CA_AMB1: sum = a_mux + ~b_mux;
      mwd_pkg::CA_APB: sum = a_mux + b_mux;
      mwd_pkg::CA_AM1: sum = a_mux - {{(CW-1){1'b0}}, 1'b1};
      mwd_pkg::CA_AP1: sum = a_mux + {{(CW-1){1'b0}}, 1'b1};
      mwd_pkg::CA_AMB: sum = a_mux - b_mux;
      mwd_pkg::CA_OR: sum = a_mux | b_mux;
      mwd_pkg::CA_AND: sum = a_mux & b_mux;
      default: sum = a_mux;
    endcase
  end

endmodule

// ---- core/mwd_datapath_select.sv ----
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Extension select: seven documented input sources, code 0 holds
// - Extension holds unless a select or the clear is asserted
// - Memory response ORs into select bit 0: cache data when microword select is 0
// - Fast transfer read ORs into select bit 1: sum when microword select is 0
// - Indirect control with magic 03 clears extension while main word busy
// - Buffer select one loads from main word
// - Buffer extension select one loads extension
// - Accumulator address plus offset, modulo sixteen
// - Index, address, block-relative fast-memory codes
// - Count adder implements eight wired functions
// - A mixer: exponent, position, exponent field, magic
// - Exponent register is ten bits wide
// - B mixer: count, size, field, magic
// - Ten-bit shift count steers the shifter
// - Alternate mode loads count from exponent/shift
// - Main bit 18 set means right shift
// - Shifter: pair, main, extension, swapped halves
// - Out-of-range count passes extension unchanged
// - Left mixer top: magic, smear, exponent, position
// - Smear, exponent and position fill widths
// - Left bits 13-17: counter or previous section
// - Address source: hold, counter, counter+1, sum
module mwd_datapath_select #(
  parameter int AW = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control store and datapath side
  input wire mwd_pkg::mwd_mword_type mword,
  input wire mwd_pkg::mwd_dpath_type dp,
  // Register outputs
  output logic [mwd_pkg::WORD_W-1:0] work_ext_reg,
  output logic [mwd_pkg::WORD_W-1:0] buffer_reg,
  output logic [mwd_pkg::WORD_W-1:0] buffer_ext_reg,
  output logic [mwd_pkg::CNT_W-1:0] shift_count_reg,
  output logic [mwd_pkg::CNT_W-1:0] exponent_reg,
  output logic [mwd_pkg::VA_W-1:0] virtual_addr_reg,
  output logic [mwd_pkg::FMA_W-1:0] fast_mem_addr,
  output logic [mwd_pkg::WORD_W-1:0] shifter_out,
  output logic [8:0] left_mix_hi,
  output logic [4:0] left_mix_sect,
  output logic left_mix_valid,
  output logic shift_right,
  // AXI4-Lite slave
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  //////////////////////////////////////////////////////////////////////////
  // Register state
  logic [mwd_pkg::WORD_W-1:0] wx_r;           // Work extension
  logic [mwd_pkg::WORD_W-1:0] buf_r;          // Buffer
  logic [mwd_pkg::WORD_W-1:0] bufx_r;         // Buffer extension
  logic [mwd_pkg::CNT_W-1:0] sc_r;            // Shift count
  logic [mwd_pkg::CNT_W-1:0] exp_r;           // Exponent
  logic [mwd_pkg::VA_W-1:0] va_r;             // Virtual address
  logic [mwd_pkg::FMA_W-1:0] fma_r;           // Fast-memory address
  logic [mwd_pkg::WORD_W-1:0] sh_r;           // Shifter output copy
  logic [8:0] lmh_r;                          // Left mixer 00-08
  logic [4:0] lms_r;                          // Left mixer 13-17
  logic lmv_r;
  logic [31:0] ctrl_r;                        // Software control
  logic run;                                  // Loads enabled

  //////////////////////////////////////////////////////////////////////////
  // Count adder
  logic [mwd_pkg::CNT_W-1:0] ca_sum;
  mwd_count_adder #(
    .CW(mwd_pkg::CNT_W)
  ) u_count_adder (
    .fn(mword.ca_fn),
    .a_sel(mword.ca_a_sel),
    .b_sel(mword.ca_b_sel),
    .magic(mword.magic),
    .exponent_reg(exp_r),
    .shift_count_reg(sc_r),
    .main_work_reg(dp.main_work_reg),
    .sum(ca_sum)
  );

  //////////////////////////////////////////////////////////////////////////
  // Shifter; only the pair shifts left, physically
  logic [71:0] pair_shl;
  logic sc_in_range;
  logic [mwd_pkg::WORD_W-1:0] sh_pair;
  logic [mwd_pkg::WORD_W-1:0] sh_mux;
  assign pair_shl = {dp.main_work_reg, wx_r} << sc_r[5:0];
  // Count is signed: top bit set reads as negative
  assign sc_in_range = !sc_r[mwd_pkg::CNT_W-1] &&
                       (sc_r <= mwd_pkg::SHIFT_MAX);
  assign sh_pair = sc_in_range ? pair_shl[71:36] : wx_r;
  assign sh_mux = (mword.sh_sel == mwd_pkg::SH_PAIR) ? sh_pair :
                  (mword.sh_sel == mwd_pkg::SH_MAIN) ? dp.main_work_reg :
                  (mword.sh_sel == mwd_pkg::SH_EXT) ? wx_r :
                  {dp.main_work_reg[17:0], dp.main_work_reg[35:18]};

  //////////////////////////////////////////////////////////////////////////
  // Work-extension input mixer
  logic [2:0] wx_eff;
  logic wx_clr;
  logic [mwd_pkg::WORD_W-1:0] wx_mux;
  // Hardware strobes OR into the microcoded select lines
  assign wx_eff = mword.wx_sel |
                  {1'b0, 1'b0, dp.memory_response_strobe} |
                  {1'b0, dp.fastmem_transfer, 1'b0};
  assign wx_clr = mword.left_half_indirect_ctl &&
                  (mword.magic == mwd_pkg::MAGIC_WX_CLR) &&
                  dp.main_work_busy;
  always_comb begin
    case (wx_eff)
      mwd_pkg::WX_UNUSED: wx_mux = wx_r;
      mwd_pkg::WX_CACHE: wx_mux = dp.cache_data;
      mwd_pkg::WX_SUM: wx_mux = dp.sum;
      mwd_pkg::WX_MQ: wx_mux = dp.mult_quot_reg;
      mwd_pkg::WX_SHIFT: wx_mux = sh_mux;
      mwd_pkg::WX_SUM2: wx_mux = {dp.sum[34:0], 1'b0};
      mwd_pkg::WX_XSUM: wx_mux = dp.extension_sum;
      mwd_pkg::WX_XSUM4: wx_mux = {{2{dp.extension_sum[35]}},
                                   dp.extension_sum[35:2]};
      default: wx_mux = wx_r;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Fast-memory address formation
  function automatic logic [3:0] ac_plus(input logic [3:0] ac,
                                         input logic [3:0] k);
    ac_plus = ac + k;                        // Wraps modulo 16
  endfunction
  logic [3:0] acf;
  logic [mwd_pkg::FMA_W-1:0] fma_nxt;
  assign acf = dp.instr_acc_field;
  always_comb begin
    case (mword.fm_sel)
      mwd_pkg::FM_AC0: fma_nxt = {dp.cur_ac_block, acf};
      mwd_pkg::FM_AC1: fma_nxt = {dp.cur_ac_block, ac_plus(acf, 4'h1)};
      mwd_pkg::FM_AC2: fma_nxt = {dp.cur_ac_block, ac_plus(acf, 4'h2)};
      mwd_pkg::FM_AC3: fma_nxt = {dp.cur_ac_block, ac_plus(acf, 4'h3)};
      mwd_pkg::FM_XR:
        fma_nxt = {3'h0, wx_r[mwd_pkg::ARX_IDX_HI:mwd_pkg::ARX_IDX_LO]};
      mwd_pkg::FM_VA: fma_nxt = {3'h0, va_r[3:0]};
      mwd_pkg::FM_CB: fma_nxt = {dp.cur_ac_block, mword.magic[3:0]};
      mwd_pkg::FM_MB: fma_nxt = mword.magic[6:0];
      default: fma_nxt = {dp.cur_ac_block, acf};
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Left-half mixer; meaningful only with no main-word select line
  logic [8:0] lmh_nxt;
  logic [4:0] lms_nxt;
  always_comb begin
    case (mword.sh_sel)
      2'h0: lmh_nxt = mword.magic;
      2'h1: lmh_nxt = {9{dp.main_work_reg[mwd_pkg::AR_SIGN]}};
      2'h2: lmh_nxt = ca_sum[8:0];
      2'h3: lmh_nxt = {ca_sum[5:0], dp.main_work_reg[29:27]};
      default: lmh_nxt = mword.magic;
    endcase
  end
  // Select-1 line picks the previous section over the counter
  assign lms_nxt = mword.sh_sel[0] ? dp.prev_sect :
                   dp.pc[mwd_pkg::PC_LH_HI:mwd_pkg::PC_LH_LO];

  //////////////////////////////////////////////////////////////////////////
  // Shift count and address next values
  logic [mwd_pkg::CNT_W-1:0] sc_nxt;
  logic [mwd_pkg::VA_W-1:0] va_nxt;
  assign sc_nxt = !mword.count_mux_alternate ? ca_sum :
                  !mword.sc_src ? exp_r :
                  {1'b0, dp.main_work_reg[mwd_pkg::AR_DIR],
                   dp.main_work_reg[7:0]};
  assign va_nxt = (mword.va_sel == mwd_pkg::VA_HOLD) ? va_r :
                  (mword.va_sel == mwd_pkg::VA_PC) ? dp.pc :
                  (mword.va_sel == mwd_pkg::VA_PC1) ?
                    dp.pc + {{(mwd_pkg::VA_W-1){1'b0}}, 1'b1} :
                  dp.sum[mwd_pkg::VA_W-1:0];

  //////////////////////////////////////////////////////////////////////////
  // Datapath registers; every load on one edge
  assign run = ctrl_r[0];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wx_r <= '0;
      buf_r <= '0;
      bufx_r <= '0;
    end else if (run) begin
      // Clear beats any load selection
      if (wx_clr)
        wx_r <= '0;
      else if (wx_eff != mwd_pkg::WX_UNUSED)
        wx_r <= wx_mux;
      if (mword.buf_sel)
        buf_r <= dp.main_work_reg;
      if (mword.bufx_sel)
        bufx_r <= wx_r;
    end
  end

  // Counters and address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sc_r <= '0;
      exp_r <= '0;
      va_r <= '0;
    end else if (run) begin
      if (mword.count_mux_alternate || mword.sc_load)
        sc_r <= sc_nxt;
      if (mword.exp_load)
        exp_r <= ca_sum;
      va_r <= va_nxt;
    end
  end

  // Registered copies of the combinational selections
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fma_r <= '0;
      sh_r <= '0;
      lmh_r <= '0;
      lms_r <= '0;
      lmv_r <= 1'b0;
    end else begin
      fma_r <= fma_nxt;
      sh_r <= sh_mux;
      lmh_r <= lmh_nxt;
      lms_r <= lms_nxt;
      lmv_r <= dp.main_sel_none;
    end
  end

  assign work_ext_reg = wx_r;
  assign buffer_reg = buf_r;
  assign buffer_ext_reg = bufx_r;
  assign shift_count_reg = sc_r;
  assign exponent_reg = exp_r;
  assign virtual_addr_reg = va_r;
  assign fast_mem_addr = fma_r;
  assign shifter_out = sh_r;
  assign left_mix_hi = lmh_r;
  assign left_mix_sect = lms_r;
  assign left_mix_valid = lmv_r;
  assign shift_right = dp.main_work_reg[mwd_pkg::AR_DIR];

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: both write channels taken in one beat
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic wr_go;
  logic rd_go;
  logic wr_hit;
  logic [31:0] rd_word;
  logic rd_hit;
  // Waiting for both keeps the slave free of a half-accepted write
  assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  assign rd_go = s_axi_arvalid && !rvalid_r;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  assign wr_hit = (s_axi_awaddr == mwd_pkg::OFS_CTRL);
  assign rd_hit = (s_axi_araddr == mwd_pkg::OFS_CTRL) ||
                  (s_axi_araddr == mwd_pkg::OFS_COUNT) ||
                  (s_axi_araddr == mwd_pkg::OFS_VADDR) ||
                  (s_axi_araddr == mwd_pkg::OFS_WEXT) ||
                  (s_axi_araddr == mwd_pkg::OFS_BUF);
  assign rd_word =
    (s_axi_araddr == mwd_pkg::OFS_CTRL) ? ctrl_r :
    (s_axi_araddr == mwd_pkg::OFS_COUNT) ?
      {shift_right, 5'h00, exp_r, 6'h00, sc_r} :
    (s_axi_araddr == mwd_pkg::OFS_VADDR) ? {9'h000, va_r} :
    (s_axi_araddr == mwd_pkg::OFS_WEXT) ? wx_r[31:0] :
    (s_axi_araddr == mwd_pkg::OFS_BUF) ? buf_r[31:0] : 32'h0000_0000;

  // Write side; control word honours byte strobe 0 only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= mwd_pkg::CTRL_RESET;
      bvalid_r <= 1'b0;
      bresp_r <= mwd_pkg::RESP_OKAY;
    end else begin
      if (wr_go && wr_hit && s_axi_wstrb[0])
        ctrl_r <= {31'h0000_0000, s_axi_wdata[0]};
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? mwd_pkg::RESP_OKAY : mwd_pkg::RESP_SLVERR;
      end else if (s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  // Read side
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rresp_r <= mwd_pkg::RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rresp_r <= rd_hit ? mwd_pkg::RESP_OKAY : mwd_pkg::RESP_SLVERR;
      rdata_r <= rd_word;
    end else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_plain_wx;
    run && !wx_clr && !dp.fastmem_transfer;
  endsequence

  a_wx_hold_idle: assert property (
    s_plain_wx ##0 (mword.wx_sel == 3'h0) && !dp.memory_response_strobe
    |=> wx_r == $past(wx_r))
    else $error("extension changed with no select");
  a_wx_resp_cache: assert property (
    s_plain_wx ##0 (mword.wx_sel == 3'h0) && dp.memory_response_strobe
    |=> wx_r == $past(dp.cache_data))
    else $error("response did not load cache data");
  a_wx_fm_sum: assert property (
    run && !wx_clr && dp.fastmem_transfer && !dp.memory_response_strobe
    && (mword.wx_sel == 3'h0) |=> wx_r == $past(dp.sum))
    else $error("fast transfer did not load sum");
  a_wx_clear: assert property (
    run && mword.left_half_indirect_ctl && dp.main_work_busy
    && (mword.magic == 9'h003) |=> wx_r == 36'h0_0000_0000)
    else $error("extension not cleared");
  a_wx_quarter: assert property (
    s_plain_wx ##0 !dp.memory_response_strobe && (mword.wx_sel == 3'h7)
    |=> wx_r[33:0] == $past(dp.extension_sum[35:2]))
    else $error("quarter sum wrong");
  a_buf_loads: assert property (
    run && mword.buf_sel && mword.bufx_sel
    |=> buf_r == $past(dp.main_work_reg) && bufx_r == $past(wx_r))
    else $error("buffer pair load wrong");
  a_bufx_hold: assert property (
    run && !mword.bufx_sel |=> $stable(bufx_r))
    else $error("buffer extension moved");
  a_fm_wrap: assert property (
    mword.fm_sel == 3'h5 |=> fma_r[3:0] == $past(acf) + 4'h3)
    else $error("accumulator offset wrong");
  a_fm_vaddr: assert property (
    mword.fm_sel == 3'h3 |=> fma_r == {3'h0, $past(va_r[3:0])})
    else $error("address index wrong");
  a_sh_range: assert property (
    mword.sh_sel == 2'h0 && sc_r > 10'h023 |=> sh_r == $past(wx_r))
    else $error("out of range count shifted");
  a_sh_swap: assert property (
    mword.sh_sel == 2'h3
    |=> sh_r[35:18] == $past(dp.main_work_reg[17:0]))
    else $error("swap wrong");
  a_sc_alt_load: assert property (
    run && mword.count_mux_alternate && mword.sc_src
    |=> sc_r[8:0] == {$past(dp.main_work_reg[17]),
                      $past(dp.main_work_reg[7:0])})
    else $error("shift count alternate load wrong");
  a_va_pc_plus: assert property (
    run && mword.va_sel == 2'h2 |=> va_r == $past(dp.pc) + 23'h000001)
    else $error("address increment wrong");
  a_lm_smear: assert property (
    mword.sh_sel == 2'h1
    |=> lmh_r == {9{$past(dp.main_work_reg[35])}}
        && lms_r == $past(dp.prev_sect))
    else $error("smear or section wrong");
  a_axi_bhold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

endmodule

// ---- testbench/mwd_mem_model.sv ----
`timescale 1ns/1ps
// Memory response side: answers a read one cycle after its request
module mwd_mem_model (
  // Clock
  input wire logic aclk,
  // Request and response
  input wire logic rd_req,
  output logic strobe,
  output logic [35:0] data
);
  // Lines float between replies, so they show the inverse of the last word
  always_ff @(posedge aclk) begin
    strobe <= rd_req;
    data <= rd_req ? 36'h0_0000_00C1 : ~data;
  end
endmodule

// ---- testbench/microword_datapath_select_tb.sv ----
`timescale 1ns/1ps
module microword_datapath_select_tb;
  // Row: selects in, register values out
  typedef struct packed {
    logic [2:0] wx;
    logic [2:0] fm;
    logic [1:0] va;
    logic [35:0] e_wx;
    logic [6:0] e_fm;
    logic [22:0] e_va;
  } mwd_row_type;
  localparam mwd_row_type ROWS [7] = '{
    '{3'h2, 3'h0, 2'h1, 36'h2, 7'h0F, 23'h10},
    '{3'h3, 3'h1, 2'h2, 36'h3, 7'h00, 23'h11},
    '{3'h4, 3'h4, 2'h0, 36'h4, 7'h01, 23'h11},
    '{3'h5, 3'h5, 2'h3, 36'h4, 7'h02, 23'h02},
    '{3'h6, 3'h6, 2'h0, 36'h8_0000_0010, 7'h2A, 23'h02},
    '{3'h7, 3'h7, 2'h0, 36'hE_0000_0004, 7'h5A, 23'h02},
    '{3'h0, 3'h0, 2'h0, 36'hE_0000_0004, 7'h0F, 23'h02}};
  logic aclk, aresetn, rd_req, strobe, shift_right, left_mix_valid;
  logic [35:0] cdata, work_ext_reg, buffer_reg, buffer_ext_reg, shifter_out;
  logic [8:0] left_mix_hi;
  logic [4:0] left_mix_sect;
  logic [9:0] shift_count_reg, exponent_reg;
  logic [22:0] virtual_addr_reg;
  logic [6:0] fast_mem_addr;
  mwd_pkg::mwd_mword_type mw;
  mwd_pkg::mwd_dpath_type dpv, dpx;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int bad_count, tests_run;
  // Memory reply lines merge into the datapath bundle
  always_comb begin
    dpx = dpv;
    dpx.memory_response_strobe = strobe;
    dpx.cache_data = cdata;
  end
  mwd_mem_model i_mem (.aclk, .rd_req, .strobe, .data(cdata));
  mwd_datapath_select i_dut (.aclk, .aresetn, .mword(mw), .dp(dpx),
    .work_ext_reg, .buffer_reg, .buffer_ext_reg, .shift_count_reg,
    .exponent_reg, .virtual_addr_reg, .fast_mem_addr, .shifter_out,
    .left_mix_hi, .left_mix_sect, .left_mix_valid, .shift_right,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  // Free-running 8 ns clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One edge, then let its updates settle
  task automatic nx;
    @(posedge aclk);
    #1;
  endtask
  // Write: address and data offered together, held until taken
  task automatic axi_wr(input logic [31:0] d);
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    #1 while (s_axi_awready !== 1'b1) nx;
    @(posedge aclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    #1 while (s_axi_bvalid !== 1'b1) nx;
    chk(s_axi_bresp, mwd_pkg::RESP_OKAY);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [33:0] exp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    #1 while (s_axi_arready !== 1'b1) nx;
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    #1 while (s_axi_rvalid !== 1'b1) nx;
    chk({s_axi_rresp, s_axi_rdata}, exp);
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Hang guard, far beyond the length of the sequence
  initial begin
    repeat (3000) @(posedge aclk);
    bad_count++;
    close_out;
  end
  initial begin
    {aresetn, rd_req, mw, dpv, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    dpv.sum = 36'h2;
    dpv.mult_quot_reg = 36'h3;
    dpv.main_work_reg = 36'h4;
    dpv.extension_sum = 36'h8_0000_0010;
    dpv.pc = 23'h10;
    dpv.instr_acc_field = 4'hF;
    dpv.cur_ac_block = 3'h2;
    mw.sh_sel = mwd_pkg::SH_MAIN;
    mw.magic = 9'h05A;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    #1 chk(work_ext_reg | buffer_reg | virtual_addr_reg, 36'h0);
    axi_rd(mwd_pkg::OFS_CTRL, {mwd_pkg::RESP_OKAY, mwd_pkg::CTRL_RESET});
    axi_rd(8'hFC, {mwd_pkg::RESP_SLVERR, 32'h0});
    foreach (ROWS[i]) begin
      @(posedge aclk);
      {mw.wx_sel, mw.fm_sel, mw.va_sel} <=
        {ROWS[i].wx, ROWS[i].fm, ROWS[i].va};
      nx;
      chk(work_ext_reg, ROWS[i].e_wx);
      chk(ROWS[i].fm > 3'h5 ? fast_mem_addr : fast_mem_addr[3:0],
        ROWS[i].e_fm);
      chk(virtual_addr_reg, ROWS[i].e_va);
    end
    @(posedge aclk);
    rd_req <= 1'b1;
    @(posedge aclk);
    rd_req <= 1'b0;
    nx;
    chk(work_ext_reg, 36'hC1);
    @(posedge aclk);
    dpv.fastmem_transfer <= 1'b1;
    nx;
    chk(work_ext_reg, 36'h2);
    @(posedge aclk);
    {mw.buf_sel, mw.bufx_sel, dpv.fastmem_transfer} <= 3'b110;
    nx;
    chk(buffer_reg, 36'h4);
    chk(buffer_ext_reg, 36'h2);
    @(posedge aclk);
    {mw.buf_sel, mw.bufx_sel} <= 2'b00;
    dpv.main_work_reg <= 36'h0_0002_0085;
    nx;
    chk(buffer_reg, 36'h4);
    chk(shift_right, 1'b1);
    @(posedge aclk);
    {mw.count_mux_alternate, mw.sc_src, mw.exp_load} <= 3'b111;
    {mw.ca_a_sel, mw.ca_fn} <= {3'h3, mwd_pkg::CA_AP1};
    nx;
    chk(shift_count_reg, 10'h185);
    chk(exponent_reg, 10'h05B);
    // Pair shift with an out-of-range count, adder A+B from count
    @(posedge aclk);
    {mw.sh_sel, mw.ca_fn} <= {mwd_pkg::SH_PAIR, mwd_pkg::CA_APB};
    {dpv.pc, dpv.prev_sect, dpv.main_sel_none} <= {23'h6C_0000, 5'h19, 1'b1};
    nx;
    chk(exponent_reg, 10'h1DF);
    chk(shifter_out, 36'h2);
    chk({left_mix_hi, left_mix_sect, left_mix_valid},
      {9'h05A, 5'h1B, 1'b1});
    // Swapped halves; left mixer in position mode
    @(posedge aclk);
    mw.sh_sel <= mwd_pkg::SH_SWAP;
    nx;
    chk(shifter_out, 36'h8_0214_0000);
    chk({left_mix_hi, left_mix_sect}, {9'h0F8, 5'h19});
    @(posedge aclk);
    {mw.left_half_indirect_ctl, dpv.main_work_busy, mw.wx_sel} <= 5'h1E;
    mw.magic <= mwd_pkg::MAGIC_WX_CLR;
    nx;
    chk(work_ext_reg, 36'h0);
    axi_wr(32'h0);
    axi_rd(mwd_pkg::OFS_CTRL, {mwd_pkg::RESP_OKAY, 32'h0});
    axi_wr(32'h1);
    close_out;
  end
endmodule
